// ---- oc_pwm_pkg.sv ----
// package for the two-channel output compare / pwm timer block
// assumes a byte-wide register port with one-cycle read latency
package oc_pwm_pkg;

  // register offsets (byte index on the plain port)
  localparam logic [3:0] ADDR_TSC      = 4'h0;
  localparam logic [3:0] ADDR_CNT_HIGH = 4'h1;
  localparam logic [3:0] ADDR_CNT_LOW  = 4'h2;
  localparam logic [3:0] ADDR_MOD_HIGH = 4'h3;
  localparam logic [3:0] ADDR_MOD_LOW  = 4'h4;
  localparam logic [3:0] ADDR_SC0      = 4'h5;
  localparam logic [3:0] ADDR_CH0_HIGH = 4'h6;
  localparam logic [3:0] ADDR_CH0_LOW  = 4'h7;
  localparam logic [3:0] ADDR_SC1      = 4'h8;
  localparam logic [3:0] ADDR_CH1_HIGH = 4'h9;
  localparam logic [3:0] ADDR_CH1_LOW  = 4'hA;

  // timer status/control field positions
  localparam int TSC_OVF  = 7;
  localparam int TSC_OIE  = 6;
  localparam int TSC_HALT = 5;
  localparam int TSC_RST  = 4;

  // channel status/control field positions
  localparam int SC_FLAG = 7;
  localparam int SC_IE   = 6;
  localparam int SC_MSB  = 5;
  localparam int SC_MSA  = 4;
  localparam int SC_ELB  = 3;
  localparam int SC_ELA  = 2;
  localparam int SC_TOV  = 1;
  localparam int SC_MAX  = 0;

  localparam logic [7:0]  TSC_RESET   = 8'h20;
  localparam logic [15:0] MOD_RESET   = 16'hFFFF;
  localparam logic [15:0] ZERO16      = 16'h0000;
  localparam logic [6:0]  PRESC_ZERO  = 7'h00;
  localparam logic [2:0]  DIV_UNUSED  = 3'h7;

  typedef struct packed {
    logic       flag;
    logic       irq_en;
    logic       msel_high;
    logic       msel_low;
    logic       edge_high;
    logic       edge_low;
    logic       tov;
    logic       max_duty;
  } chan_ctrl_type;

  typedef struct packed {
    logic       out;
    logic       oe;
  } pin_drive_type;

  typedef enum logic [1:0] {
    ACT_CH0 = 2'b01,
    ACT_CH1 = 2'b10
  } active_set_type;

endpackage

// ---- oc_channel.sv ----
// one compare channel: match detect and output latch update
// assumes counter, wrap event and compare value come from the same clock
`timescale 1ns/10ps
module oc_channel
(
  // clock and reset
  input  wire logic                    clock,
  input  wire logic                    reset,
  // timing
  input  wire logic                    tick,
  input  wire logic [15:0]             count,
  input  wire logic                    wrap,
  input  wire logic [15:0]             compare,
  input  wire oc_pwm_pkg::chan_ctrl_type ctrl,
  input  wire logic                    enable,
  // results
  output logic                         match,
  output logic                         level_q
);

  logic level_d;

  // count is the value the counter moves to on this tick, so the action lands
  // as the counter arrives; exact equality only, a passed value waits a period
  assign match = enable && tick && (count == compare);

  always_comb
  begin
    level_d = level_q;
    if (enable && ctrl.max_duty && ctrl.tov)
      level_d = 1'b1;
    else if (enable)
    begin
      // compare action wins over a same-tick overflow toggle
      if (match)
      begin
        case ({ctrl.edge_high, ctrl.edge_low})
          2'b01:   level_d = ~level_q;
          2'b10:   level_d = 1'b0;
          2'b11:   level_d = 1'b1;
          default: level_d = level_q;
        endcase
      end
      else if (wrap && ctrl.tov)
        level_d = ~level_q;
    end
  end

  always_ff @(posedge clock)
  begin
    if (reset)
      level_q <= 1'b0;
    else
      level_q <= level_d;
  end

  a_max_holds_high: assert property (@(posedge clock) disable iff (reset)
    (enable && ctrl.max_duty && ctrl.tov) |=> level_q)
    else $error("max duty did not hold output high");

  a_clear_on_match: assert property (@(posedge clock) disable iff (reset)
    (match && !ctrl.max_duty && ctrl.edge_high && !ctrl.edge_low) |=> !level_q)
    else $error("clear action did not drive low");

endmodule

// ---- oc_pwm_top.sv ----
// output compare and pwm timer: counter, prescaler, two channels, linking
// assumes a byte register port and external pins with separate enables
`timescale 1ns/10ps
module oc_pwm_top
(
  // clock and reset
  input  wire logic                      clock,
  input  wire logic                      reset,
  // register port
  input  wire logic [3:0]                addr,
  input  wire logic [7:0]                wdata,
  input  wire logic                      wr,
  input  wire logic                      rd,
  output logic      [7:0]                rdata,
  // interrupt requests
  output logic                           ovf_irq,
  output logic                           chan0_irq,
  output logic                           chan1_irq,
  // pins
  output oc_pwm_pkg::pin_drive_type      chan0_pin,
  output oc_pwm_pkg::pin_drive_type      chan1_pin
);

  // timer status/control state
  logic        ovf_q, ovf_d, oie_q, oie_d, halt_q, halt_d, rst_q, rst_d;
  logic        ovf_armed_q, ovf_armed_d;
  logic [2:0]  div_q, div_d;
  logic [6:0]  presc_q, presc_d;
  logic [15:0] count_q, count_d, mod_q, mod_d, cmp0_q, cmp0_d, cmp1_q, cmp1_d;
  logic [7:0]  cnt_low_latch_q, cnt_low_latch_d;
  oc_pwm_pkg::chan_ctrl_type sc0_q, sc0_d, sc1_q, sc1_d;
  logic        f0_armed_q, f0_armed_d, f1_armed_q, f1_armed_d;
  oc_pwm_pkg::active_set_type act_q, act_d;
  logic        pend1_q, pend1_d, pend0_q, pend0_d;
  logic [7:0]  rdata_d;
  logic        ovf_irq_d, chan0_irq_d, chan1_irq_d;
  oc_pwm_pkg::pin_drive_type pin0_d, pin1_d;

  logic        tick, wrap, linked, oc0, oc1, m0, m1, lvl0, lvl1;
  logic [15:0] cmp0_use, count_next;
  logic        tick_mask;

  // prescaler tap: code 111 is unused and stalls the counter
  always_comb
  begin
    case (div_q)
      3'h0:    tick_mask = 1'b1;
      3'h1:    tick_mask = presc_q[0:0] == 1'h1;
      3'h2:    tick_mask = presc_q[1:0] == 2'h3;
      3'h3:    tick_mask = presc_q[2:0] == 3'h7;
      3'h4:    tick_mask = presc_q[3:0] == 4'hF;
      3'h5:    tick_mask = presc_q[4:0] == 5'h1F;
      3'h6:    tick_mask = presc_q[5:0] == 6'h3F;
      default: tick_mask = 1'b0;
    endcase
  end

  assign tick   = !halt_q && !rst_q && tick_mask;
  assign wrap   = tick && (count_q == mod_q);
  assign linked = sc0_q.msel_high;
  // linked pair always acts as an output compare, msel_low ignored
  assign oc0    = linked || sc0_q.msel_low || sc0_q.edge_high || sc0_q.edge_low;
  assign oc1    = !linked && (sc1_q.msel_low || sc1_q.edge_high || sc1_q.edge_low);
  assign cmp0_use = (linked && act_q == oc_pwm_pkg::ACT_CH1) ? cmp1_q : cmp0_q;
  // the channels compare against the arriving count so that overflow toggle
  // and compare action line up: a compare of 128 in 256 gives exactly half
  assign count_next = rst_q ? oc_pwm_pkg::ZERO16
                    : (wrap ? oc_pwm_pkg::ZERO16
                    : (tick ? count_q + 16'h0001 : count_q));

  oc_channel u_ch0
  (
    .clock   (clock),
    .reset   (reset),
    .tick    (tick),
    .count   (count_next),
    .wrap    (wrap),
    .compare (cmp0_use),
    .ctrl    (sc0_q),
    .enable  (oc0),
    .match   (m0),
    .level_q (lvl0)
  );

  oc_channel u_ch1
  (
    .clock   (clock),
    .reset   (reset),
    .tick    (tick),
    .count   (count_next),
    .wrap    (wrap),
    .compare (cmp1_q),
    .ctrl    (sc1_q),
    .enable  (oc1),
    .match   (m1),
    .level_q (lvl1)
  );

  always_comb
  begin
    ovf_d = ovf_q; oie_d = oie_q; halt_d = halt_q; rst_d = 1'b0;
    ovf_armed_d = ovf_armed_q; div_d = div_q;
    presc_d = presc_q + 7'h01;
    count_d = count_next;
    mod_d = mod_q; cmp0_d = cmp0_q; cmp1_d = cmp1_q;
    cnt_low_latch_d = cnt_low_latch_q;
    sc0_d = sc0_q; sc1_d = sc1_q;
    f0_armed_d = f0_armed_q; f1_armed_d = f1_armed_q;
    act_d = act_q; pend1_d = pend1_q; pend0_d = pend0_q;
    rdata_d = 8'h00;

    if (rst_q)
      presc_d = oc_pwm_pkg::PRESC_ZERO;

    // software side first, hardware sets below win over clears
    if (rd)
    begin
      case (addr)
        oc_pwm_pkg::ADDR_TSC:
        begin
          rdata_d = {ovf_q, oie_q, halt_q, 1'b0, 1'b0, div_q};
          ovf_armed_d = ovf_q;
        end
        oc_pwm_pkg::ADDR_CNT_HIGH:
        begin
          rdata_d = count_q[15:8];
          cnt_low_latch_d = count_q[7:0];
        end
        oc_pwm_pkg::ADDR_CNT_LOW:  rdata_d = cnt_low_latch_q;
        oc_pwm_pkg::ADDR_MOD_HIGH: rdata_d = mod_q[15:8];
        oc_pwm_pkg::ADDR_MOD_LOW:  rdata_d = mod_q[7:0];
        oc_pwm_pkg::ADDR_SC0:
        begin
          rdata_d = sc0_q;
          f0_armed_d = sc0_q.flag;
        end
        oc_pwm_pkg::ADDR_CH0_HIGH: rdata_d = cmp0_q[15:8];
        oc_pwm_pkg::ADDR_CH0_LOW:  rdata_d = cmp0_q[7:0];
        oc_pwm_pkg::ADDR_SC1:
        begin
          rdata_d = {sc1_q.flag, sc1_q.irq_en, 1'b0, sc1_q.msel_low, sc1_q.edge_high,
                     sc1_q.edge_low, sc1_q.tov, sc1_q.max_duty};
          f1_armed_d = sc1_q.flag;
        end
        oc_pwm_pkg::ADDR_CH1_HIGH: rdata_d = cmp1_q[15:8];
        oc_pwm_pkg::ADDR_CH1_LOW:  rdata_d = cmp1_q[7:0];
        default:                   rdata_d = 8'h00;
      endcase
    end

    if (wr)
    begin
      case (addr)
        oc_pwm_pkg::ADDR_TSC:
        begin
          if (ovf_armed_q && !wdata[oc_pwm_pkg::TSC_OVF])
            ovf_d = 1'b0;
          ovf_armed_d = 1'b0;
          oie_d  = wdata[oc_pwm_pkg::TSC_OIE];
          halt_d = wdata[oc_pwm_pkg::TSC_HALT];
          rst_d  = wdata[oc_pwm_pkg::TSC_RST];
          div_d  = wdata[2:0];
        end
        oc_pwm_pkg::ADDR_MOD_HIGH: mod_d[15:8] = wdata;
        oc_pwm_pkg::ADDR_MOD_LOW:  mod_d[7:0]  = wdata;
        oc_pwm_pkg::ADDR_SC0:
        begin
          if (f0_armed_q && !wdata[oc_pwm_pkg::SC_FLAG])
            sc0_d.flag = 1'b0;
          f0_armed_d = 1'b0;
          sc0_d[6:0] = wdata[6:0];
        end
        oc_pwm_pkg::ADDR_CH0_HIGH:
        begin
          cmp0_d[15:8] = wdata;
          pend0_d = 1'b1;
        end
        oc_pwm_pkg::ADDR_CH0_LOW:
        begin
          cmp0_d[7:0] = wdata;
          pend0_d = 1'b1;
        end
        oc_pwm_pkg::ADDR_SC1:
        begin
          if (f1_armed_q && !wdata[oc_pwm_pkg::SC_FLAG])
            sc1_d.flag = 1'b0;
          f1_armed_d = 1'b0;
          sc1_d[6:0] = {wdata[6], 1'b0, wdata[4:0]};
        end
        oc_pwm_pkg::ADDR_CH1_HIGH:
        begin
          cmp1_d[15:8] = wdata;
          pend1_d = 1'b1;
        end
        oc_pwm_pkg::ADDR_CH1_LOW:
        begin
          cmp1_d[7:0] = wdata;
          pend1_d = 1'b1;
        end
        default: ;
      endcase
    end

    // a pending written pair takes over at overflow; if both pairs were written, the one not active takes over
    if (!linked)
    begin
      act_d = oc_pwm_pkg::ACT_CH0;
      pend0_d = 1'b0;
      pend1_d = 1'b0;
    end
    else if (wrap)
    begin
      if (pend1_d && !(pend0_d && act_q == oc_pwm_pkg::ACT_CH1))
        act_d = oc_pwm_pkg::ACT_CH1;
      else if (pend0_d)
        act_d = oc_pwm_pkg::ACT_CH0;
      pend0_d = 1'b0;
      pend1_d = 1'b0;
    end

    if (wrap)
      ovf_d = 1'b1;
    if (m0)
      sc0_d.flag = 1'b1;
    if (m1)
      sc1_d.flag = 1'b1;

    ovf_irq_d   = ovf_d && oie_d;
    chan0_irq_d = sc0_d.flag && sc0_d.irq_en;
    chan1_irq_d = !linked && sc1_d.flag && sc1_d.irq_en;

    pin0_d.oe  = oc0;
    pin0_d.out = lvl0;
    pin1_d.oe  = oc1;
    pin1_d.out = lvl1;
  end

  always_ff @(posedge clock)
  begin
    if (reset)
    begin
      ovf_q <= 1'b0; oie_q <= 1'b0; halt_q <= oc_pwm_pkg::TSC_RESET[oc_pwm_pkg::TSC_HALT];
      rst_q <= 1'b0; ovf_armed_q <= 1'b0; div_q <= 3'h0;
      presc_q <= oc_pwm_pkg::PRESC_ZERO; count_q <= oc_pwm_pkg::ZERO16;
      mod_q <= oc_pwm_pkg::MOD_RESET; cmp0_q <= oc_pwm_pkg::ZERO16;
      cmp1_q <= oc_pwm_pkg::ZERO16; cnt_low_latch_q <= 8'h00;
      sc0_q <= '0; sc1_q <= '0; f0_armed_q <= 1'b0; f1_armed_q <= 1'b0;
      act_q <= oc_pwm_pkg::ACT_CH0; pend0_q <= 1'b0; pend1_q <= 1'b0;
      rdata <= 8'h00; ovf_irq <= 1'b0; chan0_irq <= 1'b0; chan1_irq <= 1'b0;
      chan0_pin <= '0; chan1_pin <= '0;
    end
    else
    begin
      ovf_q <= ovf_d; oie_q <= oie_d; halt_q <= halt_d;
      rst_q <= rst_d; ovf_armed_q <= ovf_armed_d; div_q <= div_d;
      presc_q <= presc_d; count_q <= count_d;
      mod_q <= mod_d; cmp0_q <= cmp0_d; cmp1_q <= cmp1_d;
      cnt_low_latch_q <= cnt_low_latch_d;
      sc0_q <= sc0_d; sc1_q <= sc1_d; f0_armed_q <= f0_armed_d; f1_armed_q <= f1_armed_d;
      act_q <= act_d; pend0_q <= pend0_d; pend1_q <= pend1_d;
      rdata <= rdata_d; ovf_irq <= ovf_irq_d; chan0_irq <= chan0_irq_d;
      chan1_irq <= chan1_irq_d; chan0_pin <= pin0_d; chan1_pin <= pin1_d;
    end
  end

  a_wrap_to_zero: assert property (@(posedge clock) disable iff (reset)
    wrap |=> (count_q == 16'h0000))
    else $error("counter did not wrap to zero");

  a_ovf_flag_set: assert property (@(posedge clock) disable iff (reset)
    wrap |=> ovf_q)
    else $error("overflow flag missing after wrap");

  a_chan_flag_set: assert property (@(posedge clock) disable iff (reset)
    m0 |=> sc0_q.flag)
    else $error("channel flag missing after match");

  a_chan_irq_gate: assert property (@(posedge clock) disable iff (reset)
    (m0 && sc0_q.irq_en && !(wr && addr == oc_pwm_pkg::ADDR_SC0)) |=> chan0_irq)
    else $error("channel irq not raised");

  a_reset_bit_zero: assert property (@(posedge clock) disable iff (reset)
    (wr && addr == oc_pwm_pkg::ADDR_TSC && wdata[oc_pwm_pkg::TSC_RST]) |=> ##1
      (count_q == 16'h0000 && !rst_q))
    else $error("reset bit did not clear counter");

  a_exact_match: assert property (@(posedge clock) disable iff (reset)
    m0 |=> (count_q == $past(cmp0_use)))
    else $error("match without equality");

  a_link_releases: assert property (@(posedge clock) disable iff (reset)
    linked |=> !chan1_pin.oe)
    else $error("channel one pin still driven when linked");

  a_unbuf_write: assert property (@(posedge clock) disable iff (reset)
    (wr && addr == oc_pwm_pkg::ADDR_CH0_LOW) |=> (cmp0_q[7:0] == $past(wdata)))
    else $error("compare write not immediate");

  a_undivided_tick: assert property (@(posedge clock) disable iff (reset)
    (div_q == 3'h0 && !halt_q && !rst_q) |-> tick)
    else $error("undivided prescaler skipped a count");

endmodule

// ---- pwm_load_model.sv ----
// external load on one channel pin: measures high time and period
// assumes a pull-down on the line, so a released pin reads low
`timescale 1ns/10ps
module pwm_load_model
(
  // clock and reset
  input  wire logic                      clock,
  input  wire logic                      reset,
  // pin
  input  wire oc_pwm_pkg::pin_drive_type pin,
  // measurements
  output logic                           level,
  output logic [15:0]                    high_len,
  output logic [15:0]                    period_len
);
  logic        last_q;
  logic [15:0] run_q;
  logic [15:0] hrun_q;

  assign level = pin.oe ? pin.out : 1'b0;

  // a period runs from one rising edge to the next
  always_ff @(posedge clock)
  begin
    last_q <= level;
    if (reset)
    begin
      run_q      <= 16'h0000;
      hrun_q     <= 16'h0000;
      high_len   <= 16'h0000;
      period_len <= 16'h0000;
    end
    else if (level && !last_q)
    begin
      period_len <= run_q;
      high_len   <= hrun_q;
      run_q      <= 16'h0001;
      hrun_q     <= 16'h0001;
    end
    else
    begin
      run_q  <= run_q + 16'h0001;
      hrun_q <= hrun_q + {15'h0000, level};
    end
  end
endmodule

// ---- oc_pwm_top_tb_top.sv ----
// testbench for the output compare and pwm block
// assumes one 20 MHz clock and the byte register port of the block
`timescale 1ns/10ps
module oc_pwm_top_tb_top;
  logic                      clock = 1'b0;
  logic                      reset = 1'b1;
  logic [3:0]                addr = 4'h0;
  logic [7:0]                wdata = 8'h00;
  logic                      wr = 1'b0;
  logic                      rd = 1'b0;
  logic [7:0]                rdata;
  logic                      ovf_irq;
  logic                      chan0_irq;
  logic                      chan1_irq;
  oc_pwm_pkg::pin_drive_type chan0_pin;
  oc_pwm_pkg::pin_drive_type chan1_pin;
  logic                      level;
  logic [15:0]               high_len;
  logic [15:0]               period_len;
  logic [15:0]               h1;
  logic [15:0]               hi;
  logic [15:0]               edges;
  logic [7:0]                d;
  int                        errors = 0;
  int                        cmp_count = 0;

  always #25 clock = ~clock;

  oc_pwm_top i_oc_pwm_top (.clock(clock), .reset(reset), .addr(addr), .wdata(wdata),
    .wr(wr), .rd(rd), .rdata(rdata), .ovf_irq(ovf_irq), .chan0_irq(chan0_irq),
    .chan1_irq(chan1_irq), .chan0_pin(chan0_pin), .chan1_pin(chan1_pin));

  pwm_load_model i_pwm_load_model (.clock(clock), .reset(reset), .pin(chan0_pin),
    .level(level), .high_len(high_len), .period_len(period_len));

  task automatic check(input string name, input logic [15:0] exp, input logic [15:0] got);
    cmp_count++;
    if (got !== exp)
    begin
      errors++;
      $display("BAD %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic wr_reg(input logic [3:0] a, input logic [7:0] v);
    @(posedge clock);
    wr    <= 1'b1;
    addr  <= a;
    wdata <= v;
    @(posedge clock);
    wr    <= 1'b0;
  endtask

  // high byte first; each byte lands on its own
  task automatic wr16(input logic [3:0] a, input logic [15:0] v);
    wr_reg(a, v[15:8]);
    wr_reg(a + 4'h1, v[7:0]);
  endtask

  task automatic rd_reg(input logic [3:0] a);
    @(posedge clock);
    rd   <= 1'b1;
    addr <= a;
    @(posedge clock);
    rd   <= 1'b0;
    #1;
    d = rdata;
  endtask

  // ends just past the edge so that registered outputs have settled
  task automatic cyc(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask

  task automatic measure(input int n);
    logic p;
    hi = 16'h0000;
    edges = 16'h0000;
    p = level;
    repeat (n)
    begin
      @(posedge clock);
      #1;
      hi = hi + {15'h0000, level};
      if (level !== p)
        edges = edges + 16'h0001;
      p = level;
    end
  endtask

  task automatic end_of_test;
    $display("comparisons %0d mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  // the whole sequence needs about 13k cycles, the prescaler sweep about 8k of it
  initial
  begin
    cyc(60000);
    errors++;
    end_of_test();
  end

  initial
  begin
    repeat (4) @(posedge clock);
    reset <= 1'b0;
    rd_reg(oc_pwm_pkg::ADDR_TSC);
    check("tsc_reset", 16'h0020, {8'h00, d});
    rd_reg(oc_pwm_pkg::ADDR_MOD_HIGH);
    check("mod_reset", 16'h00FF, {8'h00, d});
    rd_reg(4'hF);
    check("unmapped", 16'h0000, {8'h00, d});
    // stop and reset, period, width, mode, then run
    wr_reg(oc_pwm_pkg::ADDR_TSC, 8'h30);
    cyc(2);
    rd_reg(oc_pwm_pkg::ADDR_CNT_HIGH);
    check("cnt_held_high", 16'h0000, {8'h00, d});
    rd_reg(oc_pwm_pkg::ADDR_CNT_LOW);
    check("cnt_held", 16'h0000, {8'h00, d});
    rd_reg(oc_pwm_pkg::ADDR_TSC);
    check("rst_reads0", 16'h0020, {8'h00, d});
    wr16(oc_pwm_pkg::ADDR_MOD_HIGH, 16'h00FF);
    wr16(oc_pwm_pkg::ADDR_CH0_HIGH, 16'h0080);
    wr_reg(oc_pwm_pkg::ADDR_SC0, 8'h5A);
    cyc(2);
    check("pin0_own", 16'h0001, {15'h0000, chan0_pin.oe});
    wr_reg(oc_pwm_pkg::ADDR_TSC, 8'h40);
    cyc(768);
    check("period", 16'h0100, period_len);
    check("duty_half", 16'h0080, high_len);
    h1 = high_len;
    check("ovf_irq", 16'h0001, {15'h0000, ovf_irq});
    check("ch0_irq", 16'h0001, {15'h0000, chan0_irq});
    @(posedge level);
    rd_reg(oc_pwm_pkg::ADDR_TSC);
    wr_reg(oc_pwm_pkg::ADDR_TSC, 8'h40);
    cyc(3);
    check("ovf_clear", 16'h0000, {15'h0000, ovf_irq});
    @(negedge level);
    rd_reg(oc_pwm_pkg::ADDR_SC0);
    check("ch0_flag", 16'h00DA, {8'h00, d});
    wr_reg(oc_pwm_pkg::ADDR_SC0, 8'h5A);
    cyc(3);
    check("ch0_clear", 16'h0000, {15'h0000, chan0_irq});
    // channel one owns its pin until the pair is linked
    wr_reg(oc_pwm_pkg::ADDR_SC1, 8'h5A);
    cyc(2);
    check("pin1_own", 16'h0001, {15'h0000, chan1_pin.oe});
    // linked pair, low mode bit also set
    wr_reg(oc_pwm_pkg::ADDR_SC0, 8'h7A);
    wr16(oc_pwm_pkg::ADDR_CH1_HIGH, 16'h00C0);
    cyc(768);
    check("buf_ch1", h1 + 16'h0040, high_len);
    check("pin1_free", 16'h0000, {15'h0000, chan1_pin.oe});
    check("ch1_irq", 16'h0000, {15'h0000, chan1_irq});
    wr16(oc_pwm_pkg::ADDR_CH0_HIGH, 16'h0040);
    cyc(768);
    check("buf_ch0", h1 - 16'h0040, high_len);
    wr_reg(oc_pwm_pkg::ADDR_SC0, 8'h1B);
    cyc(300);
    measure(256);
    check("duty_full", 16'h0100, hi);
    wr_reg(oc_pwm_pkg::ADDR_SC0, 8'h18);
    cyc(300);
    measure(256);
    check("duty_zero", 16'h0000, hi);
    wr_reg(oc_pwm_pkg::ADDR_SC0, 8'h1C);
    cyc(300);
    check("edge_set", 16'h0001, {15'h0000, level});
    wr_reg(oc_pwm_pkg::ADDR_SC0, 8'h14);
    cyc(300);
    measure(512);
    check("edge_toggle", 16'h0002, edges);
    // short period so every divider code 0 to 6 fits in the run
    wr_reg(oc_pwm_pkg::ADDR_TSC, 8'h30);
    cyc(2);
    rd_reg(oc_pwm_pkg::ADDR_CNT_HIGH);
    check("cnt_rst_high", 16'h0000, {8'h00, d});
    rd_reg(oc_pwm_pkg::ADDR_CNT_LOW);
    check("cnt_rst_low", 16'h0000, {8'h00, d});
    wr16(oc_pwm_pkg::ADDR_MOD_HIGH, 16'h000F);
    wr16(oc_pwm_pkg::ADDR_CH0_HIGH, 16'h0008);
    wr_reg(oc_pwm_pkg::ADDR_SC0, 8'h1A);
    for (int k = 0; k < 7; k++)
    begin
      wr_reg(oc_pwm_pkg::ADDR_TSC, 8'(k));
      rd_reg(oc_pwm_pkg::ADDR_TSC);
      check("div_code", 16'(k), {13'h0000, d[2:0]});
      cyc(64 << k);
      check("div_period", 16'(16 << k), period_len);
    end
    end_of_test();
  end
endmodule
